// [core/scs_defines.svh]
// Register map, field positions and timing counts of the serial port
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH
`define SCS_ADDR_CFG 8'ha1
`define SCS_ADDR_CTRL 8'ha3
`define SCS_ADDR_DATA 8'ha4
`define SCS_BIT_BUSY 7
`define SCS_BIT_MST 6
`define SCS_BIT_CPHA 5
`define SCS_BIT_CPOL 4
`define SCS_BIT_SEL 3
`define SCS_BIT_RAW 2
`define SCS_BIT_SHIFTER_EMPTY_FLAG 1
`define SCS_BIT_RXE 0
`define SCS_BIT_EN 0
`define SCS_BYTE_ZERO 8'h00
`define SCS_CLK_NS 20
`define SCS_SCK_HALF_NS 80
`define SCS_SCK_HALF_CYC (`SCS_SCK_HALF_NS / `SCS_CLK_NS)
`define SCS_BIT_CYC (2 * `SCS_SCK_HALF_CYC)
`define SCS_DIV_W 4
`define SCS_DEGLITCH_CYC 2'h3
`define SCS_LAST_BIT 3'h7
`define SCS_FIFO_DEPTH 16
`define SCS_FIFO_AW 4
`endif

// [core/scs_pkg.sv]
// Types shared by the serial port files
package scs_pkg;
  typedef enum logic {SCS_IDLE, SCS_XFER} scs_mst_state_t;
endpackage

// [core/scs_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module scs_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } scs_sync_st_t;
  scs_sync_st_t st_reg;
  scs_sync_st_t st_next;

  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg <= {RST_VAL, RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule

// [core/scs_fifo.sv]
// Receive FIFO with valid and ready on both sides
`timescale 1ns/1ns
module scs_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } scs_fifo_st_t;
  scs_fifo_st_t st_reg;
  scs_fifo_st_t st_next;
  logic [W-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (st_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[st_reg.rp];

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
    if (push) begin
      mem[st_reg.wp] <= in_data;
    end
  end
endmodule

// [core/scs_port.sv]
// Serial port with configuration and status register
`timescale 1ns/1ns
`include "scs_defines.svh"
// Summary of operation
// - The busy flag reads 1 while any transfer runs, master or slave.
// - Master-select 0 runs the port as slave, 1 as clock-driving master.
// - Phase 0 centres each bit on the first clock edge, phase 1 on the second.
// - The serial clock idles low with polarity 0 and high with polarity 1.
// - The selected flag reads 1 while slave-select is low, else 0.
// - The selected flag comes from a deglitched copy of slave-select.
// - The raw select bit returns the unfiltered slave-select pin level.
// - As slave the shifter-empty flag sets when nothing is in or pending.
// - Shifter-empty clears on a transmit load or on any serial clock edge seen as an enabled, selected slave.
// - As master the shifter-empty flag always reads 1.
// - As slave receive-empty is 1 with no unread data and 0 with some.
// - As master the receive-empty flag always reads 1.
// - As slave incoming data is sampled in the middle of each bit.
// - As master input is sampled one clock before each bit period ends.
// - As slave the port acts only while selected; select fall resets count.
module scs_port (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic slave_select_line_n
);
  typedef struct packed {
    logic mst;
    logic cpha;
    logic cpol;
    logic en;
    logic [7:0] tx;
    logic tx_full;
    logic [7:0] sh;
    logic sh_loaded;
    logic [7:0] rx_sh;
    logic [2:0] bit_cnt;
    scs_pkg::scs_mst_state_t mstate;
    logic [`SCS_DIV_W-1:0] div;
    logic sck_prev;
    logic ss_filt;
    logic ss_prev;
    logic [1:0] glitch_cnt;
    logic slv_busy;
    logic shifter_empty_flag;
    logic push;
    logic [7:0] push_data;
    logic [7:0] rdata;
  } scs_st_t;
  scs_st_t st_reg;
  scs_st_t st_next;

  logic [3:0] pins_s;
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic ss_s;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [7:0] fifo_data;
  logic busy;
  logic sel;
  logic slv_act;
  logic edge_any;
  logic edge_lead;
  logic samp_edge;
  logic shift_edge;
  logic [7:0] cfg_read;
  logic sck_active;
  logic mst_start;
  logic rd_cfg;
  logic rd_ctrl;
  logic rd_data;
  logic wr_cfg;
  logic wr_ctrl;
  logic wr_data;
  logic slv_end_edge;
  logic shifter_empty_flag_flag;
  logic rxe_flag;

  // Pins cross into the core clock through two flops
  scs_sync #(
    .W(4),
    .RST_VAL(4'h1)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({sck_i, mosi_i, miso_i, slave_select_line_n}),
    .q(pins_s)
  );
  assign {sck_s, mosi_s, miso_s, ss_s} = pins_s;

  scs_fifo #(
    .W(8),
    .DEPTH(`SCS_FIFO_DEPTH),
    .AW(`SCS_FIFO_AW)
  ) u_rx_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(st_reg.push),
    .in_ready(fifo_in_ready),
    .in_data(st_reg.push_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] s,
                                          input logic b);
    shift_in = {s[6:0], b};
  endfunction

  // Strobe decode, shared by the read mux and the write path
  assign rd_cfg = rd && hit(addr, `SCS_ADDR_CFG);
  assign rd_ctrl = rd && hit(addr, `SCS_ADDR_CTRL);
  assign rd_data = rd && hit(addr, `SCS_ADDR_DATA);
  assign wr_cfg = wr && hit(addr, `SCS_ADDR_CFG);
  assign wr_ctrl = wr && hit(addr, `SCS_ADDR_CTRL);
  assign wr_data = wr && hit(addr, `SCS_ADDR_DATA);
  assign fifo_pop = rd_data;

  // Selected state from the filtered select level
  assign sel = !st_reg.ss_filt;
  assign slv_act = st_reg.en && !st_reg.mst && sel;
  assign edge_any = slv_act && (sck_s != st_reg.sck_prev);
  // Leading edge leaves the idle level set by polarity
  assign edge_lead = edge_any && (st_reg.sck_prev == st_reg.cpol);
  // Sample on the edge the bit is centred on
  assign samp_edge = st_reg.cpha ? (edge_any && !edge_lead)
                                 : edge_lead;
  assign shift_edge = edge_any && !samp_edge;
  // Phase 0: the shift edge after the eighth sample closes the byte
  assign slv_end_edge = shift_edge && !st_reg.cpha &&
                        (st_reg.bit_cnt == 3'h0);
  assign busy = (st_reg.mstate == scs_pkg::SCS_XFER) ||
                st_reg.slv_busy;

  // Master clock: active half placed by phase, idle level by polarity
  assign sck_active = st_reg.cpha
    ? (st_reg.div < `SCS_DIV_W'(`SCS_SCK_HALF_CYC))
    : (st_reg.div >= `SCS_DIV_W'(`SCS_SCK_HALF_CYC));
  assign sck_o = st_reg.cpol ^ ((st_reg.mstate == scs_pkg::SCS_XFER) &&
                 sck_active);
  assign sck_oe = st_reg.en && st_reg.mst;
  assign mosi_o = st_reg.sh[7];
  assign mosi_oe = st_reg.en && st_reg.mst;
  assign miso_o = st_reg.sh[7];
  assign miso_oe = slv_act;
  assign rdata = st_reg.rdata;

  // Room is checked including a push still in flight
  assign mst_start = st_reg.en && st_reg.mst &&
    (st_reg.mstate == scs_pkg::SCS_IDLE) && st_reg.tx_full &&
    fifo_in_ready && !st_reg.push;

  // Both empty flags only carry meaning as slave
  assign shifter_empty_flag_flag = st_reg.mst || st_reg.shifter_empty_flag;
  assign rxe_flag = st_reg.mst || !fifo_out_valid;

  always_comb begin
    cfg_read = `SCS_BYTE_ZERO;
    cfg_read[`SCS_BIT_BUSY] = busy;
    cfg_read[`SCS_BIT_MST] = st_reg.mst;
    cfg_read[`SCS_BIT_CPHA] = st_reg.cpha;
    cfg_read[`SCS_BIT_CPOL] = st_reg.cpol;
    cfg_read[`SCS_BIT_SEL] = sel;
    cfg_read[`SCS_BIT_RAW] = ss_s;
    cfg_read[`SCS_BIT_SHIFTER_EMPTY_FLAG] = shifter_empty_flag_flag;
    cfg_read[`SCS_BIT_RXE] = rxe_flag;
  end

  always_comb begin
    st_next = st_reg;
    st_next.push = 1'b0;
    st_next.sck_prev = sck_s;
    st_next.ss_prev = st_reg.ss_filt;

    // Bus read, data one cycle later; unmapped reads as zero
    st_next.rdata = st_reg.rdata;
    if (rd_cfg) begin
      st_next.rdata = cfg_read;
    end else if (rd_ctrl) begin
      st_next.rdata = {7'h00, st_reg.en};
    end else if (rd_data) begin
      st_next.rdata = fifo_out_valid ? fifo_data : `SCS_BYTE_ZERO;
    end else if (rd) begin
      st_next.rdata = `SCS_BYTE_ZERO;
    end

    // Bus writes; status bits are read-only
    if (wr_cfg) begin
      st_next.mst = wdata[`SCS_BIT_MST];
      st_next.cpha = wdata[`SCS_BIT_CPHA];
      st_next.cpol = wdata[`SCS_BIT_CPOL];
    end
    if (wr_ctrl) begin
      st_next.en = wdata[`SCS_BIT_EN];
    end
    // A write while the buffer is full is dropped
    if (wr_data && !st_reg.tx_full) begin
      st_next.tx = wdata;
      st_next.tx_full = 1'b1;
    end

    // Deglitch: level must hold several clocks before it is believed
    // Trade-off: glitch immunity costs four clocks of select latency
    if (ss_s == st_reg.ss_filt) begin
      st_next.glitch_cnt = 2'h0;
    end else if (st_reg.glitch_cnt == `SCS_DEGLITCH_CYC) begin
      st_next.ss_filt = ss_s;
      st_next.glitch_cnt = 2'h0;
    end else begin
      st_next.glitch_cnt = st_reg.glitch_cnt + 2'h1;
    end

    if (st_reg.mst) begin
      // Master engine
      st_next.slv_busy = 1'b0;
      case (st_reg.mstate)
        scs_pkg::SCS_IDLE: begin
          st_next.div = '0;
          if (mst_start) begin
            st_next.sh = st_reg.tx;
            st_next.tx_full = 1'b0;
            st_next.bit_cnt = 3'h0;
            st_next.mstate = scs_pkg::SCS_XFER;
          end
        end
        scs_pkg::SCS_XFER: begin
          st_next.div = st_reg.div + `SCS_DIV_W'(1);
          // Last clock of the bit: slave input has settled longest
          if (st_reg.div == `SCS_DIV_W'(`SCS_BIT_CYC - 1)) begin
            st_next.rx_sh = shift_in(st_reg.rx_sh, miso_s);
            st_next.div = '0;
            st_next.sh = {st_reg.sh[6:0], 1'b0};
            st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
            if (st_reg.bit_cnt == `SCS_LAST_BIT) begin
              st_next.push = 1'b1;
              st_next.push_data = shift_in(st_reg.rx_sh, miso_s);
              st_next.mstate = scs_pkg::SCS_IDLE;
            end
          end
        end
        default: begin
          st_next.mstate = scs_pkg::SCS_IDLE;
        end
      endcase
    end else begin
      // Slave engine
      // Three-wire slave is not supported: idle select ignores the clock
      st_next.mstate = scs_pkg::SCS_IDLE;
      st_next.div = '0;
      if (st_reg.ss_prev && !st_reg.ss_filt) begin
        st_next.bit_cnt = 3'h0;
        st_next.slv_busy = 1'b0;
      end else if (samp_edge) begin
        st_next.rx_sh = shift_in(st_reg.rx_sh, mosi_s);
        st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
        st_next.slv_busy = 1'b1;
        if (st_reg.bit_cnt == `SCS_LAST_BIT) begin
          // Full FIFO drops the byte: overrun
          st_next.push = 1'b1;
          st_next.push_data = shift_in(st_reg.rx_sh, mosi_s);
          st_next.sh_loaded = 1'b0;
          st_next.slv_busy = 1'b0;
        end
      end else if (shift_edge) begin
        st_next.slv_busy = !slv_end_edge;
        if (st_reg.bit_cnt == 3'h0) begin
          // Byte boundary: take the next byte or hold
          if (st_reg.tx_full) begin
            st_next.sh = st_reg.tx;
            st_next.tx_full = 1'b0;
            st_next.sh_loaded = 1'b1;
          end
        end else begin
          st_next.sh = {st_reg.sh[6:0], 1'b1};
        end
      end
      // Empty shifter takes the buffer at once
      if (!st_reg.sh_loaded && !st_reg.slv_busy && st_reg.tx_full &&
          !edge_any) begin
        st_next.sh = st_reg.tx;
        st_next.tx_full = 1'b0;
        st_next.sh_loaded = 1'b1;
      end
      // Rising select ends any byte in progress
      if (!sel) begin
        st_next.slv_busy = 1'b0;
      end
    end

    // Shifter-empty tracking
    if (edge_any || (st_next.sh_loaded && !st_reg.sh_loaded)) begin
      st_next.shifter_empty_flag = 1'b0;
    end else if (!st_reg.mst && !st_reg.slv_busy && !st_reg.sh_loaded &&
                 !st_reg.tx_full && !st_reg.push) begin
      st_next.shifter_empty_flag = 1'b1;
    end

    // Disable parks both engines and restarts the byte
    if (!st_reg.en) begin
      st_next.mstate = scs_pkg::SCS_IDLE;
      st_next.bit_cnt = 3'h0;
      st_next.slv_busy = 1'b0;
      st_next.div = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.ss_filt <= 1'b1;
      st_reg.ss_prev <= 1'b1;
      st_reg.sck_prev <= 1'b1;
      st_reg.shifter_empty_flag <= 1'b1;
      st_reg.mstate <= scs_pkg::SCS_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// [verification/scs_port_sva.sv]
// Property checker for the serial port register and link pins
`timescale 1ns/1ns
`include "scs_defines.svh"
module scs_port_sva (
  input logic clock,
  input logic rst_n,
  input logic [7:0] addr,
  input logic [7:0] wdata,
  input logic wr,
  input logic rd,
  input logic [7:0] rdata,
  input logic sck_o,
  input logic sck_oe,
  input logic mosi_o,
  input logic mosi_oe,
  input logic miso_oe,
  input logic slave_select_line_n
);
  // Master, phase, polarity as software last wrote them
  logic [2:0] mode_reg;
  logic [2:0] mode_next;
  always_comb begin
    mode_next = mode_reg;
    if (wr && addr == `SCS_ADDR_CFG)
      mode_next = wdata[6:4];
  end
  always_ff @(posedge clock) begin
    if (!rst_n)
      mode_reg <= 3'h0;
    else
      mode_reg <= mode_next;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence cfg_read;
    rd && addr == `SCS_ADDR_CFG;
  endsequence
  sequence sel_steady;
    $stable(slave_select_line_n) [*8];
  endsequence
  // Phase 0 toggles stay four clocks apart, so eight means idle
  sequence link_idle;
    (sck_oe && $stable(sck_o)) [*8];
  endsequence
  chk_rdata_hold: assert property (!rd |=> $stable(rdata))
    else $error("read data moved without a read");
  chk_cfg_bits: assert property (
    cfg_read |=> rdata[6:4] == $past(mode_reg))
    else $error("writable bits differ from last write");
  chk_master_flags: assert property (
    cfg_read |=> !rdata[6] || rdata[1:0] == 2'h3)
    else $error("master mode empty flags not one");
  chk_busy_seen: assert property (
    cfg_read ##0 (sck_oe && sck_o != mode_reg[0]) |=> rdata[7])
    else $error("busy low while clock active");
  chk_idle_level: assert property (
    link_idle |-> sck_o == mode_reg[0])
    else $error("idle clock not at polarity");
  chk_master_oe: assert property (
    sck_oe |-> mosi_oe && !miso_oe && mode_reg[2])
    else $error("drivers wrong for master");
  chk_slave_quiet: assert property (
    slave_select_line_n [*8] |-> !miso_oe)
    else $error("slave drives while unselected");
  chk_select_bits: assert property (
    sel_steady ##0 cfg_read |=> rdata[3:2] ==
      {~$past(slave_select_line_n), $past(slave_select_line_n)})
    else $error("select bits wrong");
  chk_mosi_center: assert property (
    sck_oe && $changed(sck_o) && ((sck_o != mode_reg[0]) != mode_reg[1])
      |-> $stable(mosi_o))
    else $error("data moved on sampling edge");
endmodule
bind scs_port scs_port_sva scs_port_sva_inst (.*);

// [verification/scs_peer.sv]
// Far side: link master for slave runs, echo for master runs
`timescale 1ns/1ns
module scs_peer (
  input logic clock,
  input logic sck_oe,
  input logic mosi_o,
  input logic miso_o,
  output logic sck_i,
  output logic mosi_i,
  output logic miso_i,
  output logic ss_n
);
  // Released return line toggles so a stale bit cannot pass
  assign miso_i = sck_oe ? mosi_o : clock;
  initial begin
    sck_i = 1'b0;
    mosi_i = 1'b0;
    ss_n = 1'b1;
  end
  task automatic xfer(input logic pol, input logic pha,
    input logic [7:0] tx, output logic [7:0] rx);
    sck_i = pol;
    #7 ss_n = 1'b0;
    repeat (8) @(posedge clock);
    // Off the core clock edge to avoid sampling races
    #3;
    for (int i = 7; i >= 0; i--) begin
      if (!pha)
        mosi_i = tx[i];
      #80 sck_i = ~pol;
      if (pha)
        mosi_i = tx[i];
      else
        rx[i] = miso_o;
      #80 sck_i = pol;
      if (pha)
        rx[i] = miso_o;
    end
    #80 ss_n = 1'b1;
    mosi_i = ~mosi_i;
    repeat (8) @(posedge clock);
  endtask
endmodule

// [verification/scs_port_test.sv]
// Self-checking bench for the serial port register and link
`timescale 1ns/1ns
`include "scs_defines.svh"
module scs_port_test;
  logic clock, rst_n, wr, rd;
  logic [7:0] addr, wdata, rdata;
  logic sck_i, sck_o, sck_oe, mosi_i, mosi_o, mosi_oe;
  logic miso_i, miso_o, miso_oe, ss_n;
  int fail_count = 0;
  int tests_run = 0;
  scs_port scs_port_inst (.clock(clock), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sck_i(sck_i),
    .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_i), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(miso_i), .miso_o(miso_o),
    .miso_oe(miso_oe), .slave_select_line_n(ss_n));
  scs_peer scs_peer_inst (.clock(clock), .sck_oe(sck_oe),
    .mosi_o(mosi_o), .miso_o(miso_o), .sck_i(sck_i), .mosi_i(mosi_i),
    .miso_i(miso_i), .ss_n(ss_n));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    check(rdata, exp);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic test_reset();
    expect_reg(`SCS_ADDR_CFG, 8'h07);
    expect_reg(8'ha2, 8'h00);
    wr_reg(`SCS_ADDR_CFG, 8'hff);
    expect_reg(`SCS_ADDR_CFG, 8'h77);
    expect_reg(`SCS_ADDR_CTRL, 8'h00);
    wr_reg(`SCS_ADDR_CTRL, 8'h01);
    expect_reg(`SCS_ADDR_CTRL, 8'h01);
    $display("reset test done");
  endtask
  task automatic test_select();
    wr_reg(`SCS_ADDR_CFG, 8'h00);
    @(posedge clock);
    scs_peer_inst.ss_n <= 1'b0;
    repeat (2) @(posedge clock);
    // Raw pin already low, filtered copy not yet
    expect_reg(`SCS_ADDR_CFG, 8'h03);
    repeat (8) @(posedge clock);
    expect_reg(`SCS_ADDR_CFG, 8'h0b);
    scs_peer_inst.ss_n <= 1'b1;
    repeat (8) @(posedge clock);
    expect_reg(`SCS_ADDR_CFG, 8'h07);
    $display("select test done");
  endtask
  task automatic test_master();
    logic [7:0] m;
    for (int k = 0; k < 4; k++) begin
      m = {2'b01, k[1:0], 4'h0};
      wr_reg(`SCS_ADDR_CFG, m);
      wr_reg(`SCS_ADDR_DATA, 8'h96 ^ m);
      repeat (16) @(posedge clock);
      expect_reg(`SCS_ADDR_CFG, 8'hc7 | m);
      repeat (60) @(posedge clock);
      expect_reg(`SCS_ADDR_CFG, 8'h47 | m);
      check({7'h00, sck_o}, {7'h00, m[4]});
      expect_reg(`SCS_ADDR_DATA, 8'h96 ^ m);
    end
    $display("master test done");
  endtask
  task automatic test_slave();
    logic [7:0] m;
    logic [7:0] got;
    for (int k = 0; k < 4; k++) begin
      m = {2'b00, k[1:0], 4'h0};
      wr_reg(`SCS_ADDR_CFG, m);
      wr_reg(`SCS_ADDR_DATA, 8'ha5 ^ m);
      expect_reg(`SCS_ADDR_CFG, 8'h05 | m);
      fork
        scs_peer_inst.xfer(m[4], m[5], 8'h3c ^ m, got);
        begin
          repeat (40) @(posedge clock);
          expect_reg(`SCS_ADDR_CFG, 8'h89 | m);
        end
      join
      check(got, 8'ha5 ^ m);
      expect_reg(`SCS_ADDR_CFG, 8'h06 | m);
      expect_reg(`SCS_ADDR_DATA, 8'h3c ^ m);
      expect_reg(`SCS_ADDR_CFG, 8'h07 | m);
    end
    $display("slave test done");
  endtask
  task automatic test_fifo();
    logic [7:0] got;
    wr_reg(`SCS_ADDR_CFG, 8'h00);
    // One byte beyond the depth must be dropped
    for (int i = 0; i <= 16; i++)
      scs_peer_inst.xfer(1'b0, 1'b0, 8'(i), got);
    for (int i = 0; i < 16; i++)
      expect_reg(`SCS_ADDR_DATA, 8'(i));
    expect_reg(`SCS_ADDR_DATA, 8'h00);
    expect_reg(`SCS_ADDR_CFG, 8'h07);
    $display("fifo test done");
  endtask
  initial begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    test_reset();
    test_select();
    test_master();
    test_slave();
    test_fifo();
    report_and_stop();
  end
  initial begin
    #400000;
    fail_count++;
    report_and_stop();
  end
endmodule
